// >>> core/pss_pkg.sv
// Package with constants for the pipelined SRAM cycle control block.
// Operation
// - A selected write load with byte lanes on takes its data two enabled cycles later.
// - Each enabled cycle with advance high after a load and before a deselect steps the burst counter.
// - Each burst write word two enabled cycles after its step goes to that burst address.
// - A new load may overlap earlier data, ending the burst while pending transfers finish.
// - While clock gating is high all inputs but reset and output enable are ignored, registers and dq_o hold, and dq_oe_o follows output enable.
// - Read latency counts only enabled edges, and later reads follow back to back.
// - A read load, a deselect and another read load still show the first data two cycles on.
// - A deselect starts nothing, lets a pending read finish, and the bus floats when idle.
// - The data outputs float after the first rising clock edge with reset high.
// - After the fourth burst step the counter wraps to its start value and keeps counting.
`default_nettype none
package pss_pkg;
    localparam int ADDR_W     = 19;
    localparam int DATA_W     = 36;
    localparam int LANES      = 4;
    localparam int BURST_W    = 2;
    localparam int PIPE_DEPTH = 2;
endpackage
`default_nettype wire

// >>> core/pss_stage.sv
// One enabled pipeline stage carrying a pending access.
`default_nettype none
module pss_stage
    import pss_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          en_i,
    input  wire logic          vld_i,
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] addr_i,
    output logic               vld_o,
    output logic               wr_o,
    output logic [AW-1:0]      addr_o
);
    typedef struct packed {
        logic          vld;
        logic          wr;
        logic [AW-1:0] addr;
    } pss_stage_s;
    pss_stage_s st_q;
    pss_stage_s st_d;
    always_comb begin
        st_d = st_q;
        if (en_i) begin
            st_d.vld  = vld_i;
            st_d.wr   = wr_i;
            st_d.addr = addr_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign vld_o  = st_q.vld;
    assign wr_o   = st_q.wr;
    assign addr_o = st_q.addr;
endmodule
`default_nettype wire

// >>> core/pss_top.sv
// Cycle control of a pipelined synchronous SRAM with a small flip-flop array.
`default_nettype none
module pss_top
    import pss_pkg::*;
#(
    parameter int AW    = ADDR_W,
    parameter int DW    = DATA_W,
    parameter int NL    = LANES,
    parameter int DEPTH = 16
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          read_not_write_i,
    input  wire logic          advance_or_load_select_i,
    input  wire logic          chip_select_first_low_i,
    input  wire logic          chip_select_second_i,
    input  wire logic          chip_select_third_low_i,
    input  wire logic          clock_gate_low_i,
    input  wire logic [NL-1:0] byte_lane_write_enables_low_i,
    input  wire logic          output_enable_low_i,
    input  wire logic          linear_order_low_i,
    input  wire logic [DW-1:0] dq_i,
    output logic      [DW-1:0] dq_o,
    output logic               dq_oe_o
);
    localparam int LW = DW / NL;
    localparam int IW = $clog2(DEPTH);

    typedef struct packed {
        logic              act;
        logic              wr;
        logic [AW-1:0]     base;
        logic [BURST_W-1:0] cnt;
        logic [DW-1:0]     dout;
        logic              drive;
        logic [NL-1:0]     lane1;
        logic [NL-1:0]     lane2;
    } pss_top_s;

    pss_top_s st_q;
    pss_top_s st_d;
    logic [DEPTH-1:0][DW-1:0] mem_q;

    logic          en;
    logic          sel;
    logic          load;
    logic          adv;
    logic          s0_vld;
    logic          s0_wr;
    logic [AW-1:0] s0_addr;
    logic          s1_vld;
    logic          s1_wr;
    logic [AW-1:0] s1_addr;
    logic          s2_vld;
    logic          s2_wr;
    logic [AW-1:0] s2_addr;
    logic [BURST_W-1:0] nxt;

    assign en   = !clock_gate_low_i;
    assign sel  = !chip_select_first_low_i && chip_select_second_i && !chip_select_third_low_i;
    assign load = en && !advance_or_load_select_i && sel;
    assign adv  = en && advance_or_load_select_i && st_q.act;
    assign nxt  = st_q.cnt + 2'd1;

    // Interleaved steps flip the low address bits and linear steps add; both wrap in two bits.

    always_comb begin
        s0_vld  = load || adv;
        s0_wr   = load ? !read_not_write_i : st_q.wr;
        s0_addr = load ? addr_i : {st_q.base[AW-1:BURST_W], st_q.base[BURST_W-1:0] ^ nxt};
        if (adv && !linear_order_low_i) begin
            s0_addr = {st_q.base[AW-1:BURST_W], st_q.base[BURST_W-1:0] + nxt};
        end
    end

    pss_stage #(.AW(AW)) u_s1 (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (en),
        .vld_i  (s0_vld),
        .wr_i   (s0_wr),
        .addr_i (s0_addr),
        .vld_o  (s1_vld),
        .wr_o   (s1_wr),
        .addr_o (s1_addr)
    );
    pss_stage #(.AW(AW)) u_s2 (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (en),
        .vld_i  (s1_vld),
        .wr_i   (s1_wr),
        .addr_i (s1_addr),
        .vld_o  (s2_vld),
        .wr_o   (s2_wr),
        .addr_o (s2_addr)
    );

    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.act  = 1'b1;
            st_d.wr   = !read_not_write_i;
            st_d.base = addr_i;
            st_d.cnt  = '0;
        end else if (adv) begin
            st_d.cnt = nxt;
        end else if (en && !advance_or_load_select_i) begin
            st_d.act = 1'b0;
        end
        if (en) begin
            // Read data is launched one enabled edge after stage one so it lands two cycles late.
            st_d.drive = s1_vld && !s1_wr;
            st_d.dout  = mem_q[s1_addr[IW-1:0]];
            // Lanes ride with their step, so a write uses the enables given with its own address.
            st_d.lane1 = ~byte_lane_write_enables_low_i;
            st_d.lane2 = st_q.lane1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Write data is taken two enabled edges after its address step with the lanes given at that step.
    always_ff @(posedge clk_i) begin
        if (en && s2_vld && s2_wr) begin
            for (int l = 0; l < NL; l++) begin
                if (st_q.lane2[l]) begin
                    mem_q[s2_addr[IW-1:0]][l*LW +: LW] <= dq_i[l*LW +: LW];
                end
            end
        end
    end

    assign dq_o    = st_q.dout;
    // Output enable gates only the driver, as an asynchronous control outside the pipeline.
    assign dq_oe_o = st_q.drive && !output_enable_low_i;

    AST_READ_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && s1_vld && !s1_wr) |=> st_q.drive)
        else $error("read data not driven after two enabled edges");
    AST_STAGE_RD: assert property (@(posedge clk_i) disable iff (rst_i)
        (load && read_not_write_i) |=> (s1_vld && !s1_wr))
        else $error("read load did not enter the pipeline");
    AST_STAGE_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        (load && !read_not_write_i) |=> (s1_vld && s1_wr))
        else $error("write load did not enter the pipeline");
    AST_S2_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
        en |=> (s2_vld == $past(s1_vld) && s2_addr == $past(s1_addr)))
        else $error("second stage did not follow the first");
    AST_DRIVE_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && s1_vld && !s1_wr) |=> st_q.dout == $past(mem_q[s1_addr[IW-1:0]]))
        else $error("read word does not match storage");
    AST_WR_NODRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && s1_vld && s1_wr) |=> !st_q.drive)
        else $error("bus driven for a write");
    AST_GATE_S1: assert property (@(posedge clk_i) disable iff (rst_i)
        !en |=> ($stable(s1_vld) && $stable(s1_addr)))
        else $error("first stage moved while gated");
    AST_GATE_S2: assert property (@(posedge clk_i) disable iff (rst_i)
        !en |=> ($stable(s2_vld) && $stable(s2_addr)))
        else $error("second stage moved while gated");
    AST_GATE_CNT: assert property (@(posedge clk_i) disable iff (rst_i)
        !en |=> ($stable(st_q.cnt) && $stable(st_q.act) && $stable(st_q.lane2)))
        else $error("burst state moved while gated");
    AST_NOADV_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && advance_or_load_select_i && !st_q.act) |=> !s1_vld)
        else $error("advance with no burst started an access");
    AST_LOAD_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
        load |=> st_q.wr == !$past(read_not_write_i))
        else $error("load took the wrong direction");
    AST_LOAD_BASE: assert property (@(posedge clk_i) disable iff (rst_i)
        load |=> st_q.base == $past(addr_i))
        else $error("load did not take the new address");
    AST_DESEL_END: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && !advance_or_load_select_i && !sel) |=> !st_q.act)
        else $error("deselect did not end the burst");
    AST_LANE_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        en |=> st_q.lane2 == $past(st_q.lane1))
        else $error("lane enables lost their step");
    AST_ADV_HI: assert property (@(posedge clk_i) disable iff (rst_i)
        adv |=> s1_addr[AW-1:BURST_W] == $past(st_q.base[AW-1:BURST_W]))
        else $error("burst step left its block");
    AST_ADV_LIN: assert property (@(posedge clk_i) disable iff (rst_i)
        (adv && !linear_order_low_i) |=>
        s1_addr[BURST_W-1:0] == $past(st_q.base[BURST_W-1:0]) + $past(st_q.cnt) + 2'd1)
        else $error("linear burst step wrong");
    AST_ADV_INT: assert property (@(posedge clk_i) disable iff (rst_i)
        (adv && linear_order_low_i) |=>
        s1_addr[BURST_W-1:0] == ($past(st_q.base[BURST_W-1:0]) ^ ($past(st_q.cnt) + 2'd1)))
        else $error("interleaved burst step wrong");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !en |=> ($stable(st_q.dout) && $stable(st_q.drive)))
        else $error("state changed while gated");
    AST_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_q.drive |-> !dq_oe_o)
        else $error("bus driven with no read due");
    AST_RESET: assert property (@(posedge clk_i)
        rst_i |=> !dq_oe_o)
        else $error("bus driven after reset");
    AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        (adv && st_q.cnt == 2'd3) |=> st_q.cnt == 2'd0)
        else $error("burst counter did not wrap");
    AST_ADV: assert property (@(posedge clk_i) disable iff (rst_i)
        adv |=> st_q.cnt == $past(st_q.cnt) + 2'd1)
        else $error("burst counter did not advance");
    AST_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        load |=> (st_q.cnt == 2'd0 && st_q.act))
        else $error("load did not restart burst");
    AST_DESEL: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && !advance_or_load_select_i && !sel) |=> !s1_vld)
        else $error("deselect started an access");
    COV_READ: cover property (@(posedge clk_i) load && read_not_write_i ##2 st_q.drive);
    COV_GATED: cover property (@(posedge clk_i) load ##1 !en ##1 en);
    COV_BURST: cover property (@(posedge clk_i) load ##1 adv ##1 adv ##1 adv ##1 adv);
    COV_WRAP: cover property (@(posedge clk_i) adv && st_q.cnt == 2'd3);
    COV_DESEL: cover property (@(posedge clk_i) load ##1 (en && !sel) ##1 st_q.drive);
endmodule
`default_nettype wire

// >>> tb/pss_ctrl_model.sv
// Controller-side model that supplies write data on the data-in bus.
`default_nettype none
module pss_ctrl_model
    import pss_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              gate_i,
    input  wire logic              adv_i,
    input  wire logic              sel_i,
    input  wire logic              rnw_i,
    output logic      [DATA_W-1:0] dq_o
);
    logic              act_q, wr_q, w0_q, w1_q;
    logic [3:0]        k_q;
    logic [DATA_W-1:0] last_q;
    // Idle cycles show the inverse of the last word, so stale data never matches.
    assign dq_o = w1_q ? DATA_W'(32'h0000_0a00) + DATA_W'(k_q) : ~last_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {act_q, wr_q, w0_q, w1_q, k_q} <= '0;
            last_q <= '0;
        end else if (!gate_i) begin
            if (!adv_i) begin
                act_q <= sel_i;
                wr_q  <= !rnw_i;
            end
            w0_q <= !adv_i ? (sel_i && !rnw_i) : (act_q && wr_q);
            w1_q <= w0_q;
            if (w1_q) begin
                k_q    <= k_q + 4'h1;
                last_q <= dq_o;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/pipelined_sram_cycle_control_test.sv
// Table-driven bench for the pipelined SRAM cycle control block.
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module pipelined_sram_cycle_control_test;
    import pss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              gate, adv, sel, rnw, lbo;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_i, dq_o;
    logic [LANES-1:0]  bwe = '0;
    logic              dq_oe_o;
    int                mismatches = 0;
    int                checks = 0;
    // Row: gate,adv,sel,rnw | addr | lbo,0,0,expected drive | expected word index.
    logic [15:0] rows [36] = '{16'h2400, 16'h4000, 16'h4000, 16'h4000, 16'h2100, 16'h0000,
        16'h0000, 16'h3400, 16'h4000, 16'h3110, 16'h0011, 16'h4014, 16'h0000, 16'h3600,
        16'h8000, 16'h3700, 16'h8012, 16'h8012, 16'h3412, 16'h0013, 16'h0010, 16'h0000,
        16'h3580, 16'h4080, 16'h4091, 16'h4090, 16'h0093, 16'h0092, 16'h0000,
        16'h3400, 16'h4000, 16'h4010, 16'h4011, 16'h4012, 16'h0013, 16'h0010};
    pss_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .read_not_write_i(rnw),
        .advance_or_load_select_i(adv), .chip_select_first_low_i(!sel),
        .chip_select_second_i(sel), .chip_select_third_low_i(1'b0),
        .clock_gate_low_i(gate), .byte_lane_write_enables_low_i(bwe),
        .output_enable_low_i(1'b0), .linear_order_low_i(lbo), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o));
    pss_ctrl_model model_u (.clk_i(clk_i), .rst_i(rst_i), .gate_i(gate), .adv_i(adv),
        .sel_i(sel), .rnw_i(rnw), .dq_o(dq_i));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic drive(input logic [15:0] r);
        {gate, adv, sel, rnw} = r[15:12];
        addr = ADDR_W'(r[11:8]);
        lbo = r[7];
    endtask
    task automatic final_report();
        $display("Counts: checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        drive(16'h0000);
        repeat (12) @(negedge clk_i);
        `CHK(dq_oe_o, 1'b0)
        rst_i = 1'b0;
        $display("Test reset done");
        // Burst write, back-to-back load, deselects, gated reads and interleaved burst.
        foreach (rows[i]) begin
            @(negedge clk_i);
            `CHK(dq_oe_o, rows[i][4])
            if (rows[i][4]) begin
                `CHK(dq_o, DATA_W'(32'h0000_0a00) + DATA_W'(rows[i][3:0]))
            end
            drive(rows[i]);
        end
        $display("Test table done");
        // A write whose lanes are all off at its load must leave the word alone.
        @(negedge clk_i);
        bwe = 4'hf;
        drive(16'h2400);
        @(negedge clk_i);
        bwe = 4'h0;
        drive(16'h0000);
        @(negedge clk_i);
        drive(16'h3400);
        repeat (2) @(negedge clk_i);
        `CHK(dq_oe_o, 1'b1)
        `CHK(dq_o, DATA_W'(32'h0000_0a00))
        $display("Test lanes done");
        // A reset right behind a read load must flush the pending read.
        @(negedge clk_i);
        drive(16'h3400);
        @(negedge clk_i);
        rst_i = 1'b1;
        drive(16'h0000);
        @(negedge clk_i);
        `CHK(dq_oe_o, 1'b0)
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK(dq_oe_o, 1'b0)
        $display("Test mid-run reset done");
        final_report();
    end
endmodule
`default_nettype wire
